// >>> verilog/eeprom_pkg.sv
// constants for the serial word eeprom command port
// assumes a 200 MHz system clock sampling all pins
package eeprom_pkg;
   // ----------------------------------------
   // frame layout
   // ----------------------------------------
   localparam int OPCODE_BITS = 8;
   localparam int ADDR_BITS_FIELD = 8;
   localparam int WORD_BITS = 16;
   localparam logic [5:0] LAST_HEADER_BIT = 6'h10;
   localparam logic [5:0] LAST_WRITE_BIT = 6'h20;
   localparam logic [3:0] WORD_LAST_BIT = 4'hF;
   // ----------------------------------------
   // operation codes
   // ----------------------------------------
   localparam logic [7:0] OP_READ = 8'hA8;
   localparam logic [7:0] OP_WRITE = 8'hA4;
   localparam logic [7:0] OP_PROGRAM_ENABLE = 8'hA3;
   localparam logic [7:0] OP_PROGRAM_DISABLE = 8'hA0;
   localparam logic [7:0] OP_FILL_ALL = 8'hAF;
   localparam logic [6:0] OP_READ_HI = 7'h54;
   localparam logic [6:0] OP_WRITE_HI = 7'h52;
   // ----------------------------------------
   // capacities
   // ----------------------------------------
   localparam logic [1:0] CAP_SMALL = 2'h0;
   localparam logic [1:0] CAP_MIDDLE = 2'h1;
   localparam logic [1:0] CAP_LARGE = 2'h2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam longint PROG_TIME_PS = 64'd10_000_000_000;
   localparam int PROG_CYCLES = int'(PROG_TIME_PS / CLK_PERIOD_PS);
   typedef enum logic [2:0] {
      ST_IDLE, ST_HEADER, ST_WRITE_DATA, ST_READ, ST_SKIP, ST_PROGRAM, ST_STATUS
   } phase_t;
endpackage : eeprom_pkg

// >>> verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin and filtered level
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_t;
   sync_t q_r, q_nxt;
   always_comb begin
      q_nxt = q_r;
      q_nxt.s1 = pin;
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      if (q_r.s2 == q_r.s3) begin
         q_nxt.lvl = q_r.s3;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_r <= {INIT, INIT, INIT, INIT};
      end else begin
         q_r <= q_nxt;
      end
   end
   assign level = q_r.lvl;
endmodule : pin_sync
`default_nettype wire

// >>> verilog/word_mem.sv
// word array with registered read data
// assumes single clock, write and read ports
`timescale 1ns/10ps
`default_nettype none
module word_mem #(
   parameter int AW = 9,
   parameter int DW = 16
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : word_mem
`default_nettype wire

// >>> verilog/eeprom_cmd_port.sv
// serial word eeprom command decoder, read shifter and write timer
// assumes pins are asynchronous to clk; memory image in word_mem
// Operation
// R1 - frame is opcode byte, address byte, then sixteen data bits if any
// R2 - frame starts when select falls while shift clock is high
// R3 - controller holds select high at least 250 ns between frames
// R4 - read code 10101000, write code 10100100 on small and middle parts
// R5 - small part: seven address bits msb first, then a zero
// R6 - enable 10100011, disable 10100000; their address field ignored
// R7 - large part: ninth address bit sits in last opcode bit
// R8 - controller never issues fill-all code 10101111
// R9 - write takes sixteen data bits; programming starts after 32nd rise
// R10 - controller keeps reset low during write and programming
// R11 - reset high during programming aborts to ready, word left incomplete
// R12 - after an abort controller raises select before new frame
// R13 - reset held high blocks every write
// R14 - programming continues whatever select does
// R15 - read output leaves high impedance at 17th fall, d15 first
// R16 - continued clocking reads next word, address advancing per word
// R17 - sequential read address wraps from top to zero
// R18 - powers up write-disabled until enable instruction runs
// R19 - writing stays enabled until disable instruction or power loss
// R20 - reads work whatever the enable state
// R21 - enable and disable ignore shift clock pulses beyond 16th
// R22 - inputs sampled on shift clock rise, read data driven on fall
// R23 - ready pin low throughout programming, high otherwise
// R24 - select falling with clock low shows status until select or a one
// R25 - programming period stays within 10 ms
// R26 - unknown opcodes are no-ops
// R27 - output high impedance during non-read frames except status mode
`timescale 1ns/10ps
`default_nettype none
module eeprom_cmd_port
   import eeprom_pkg::*;
#(
   parameter logic [1:0] CAPACITY = CAP_LARGE,
   parameter int PROG_CYCLES_P = PROG_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic shift_clock_n,
   input wire logic select_n,
   input wire logic serial_in,
   input wire logic abort_reset,
   // serial output, two signals of a tri-state pin
   output logic serial_out_o,
   output logic serial_out_oe_n,
   // ready/busy pin
   output logic ready
);
   localparam int AW = 9;
   typedef struct packed {
      phase_t phase;
      logic sk_d;
      logic sel_d;
      logic [5:0] bitcnt;
      logic [7:0] opcode;
      logic [7:0] addr_field;
      logic [15:0] data;
      logic [AW-1:0] addr;
      logic [3:0] rdbit;
      logic [15:0] shreg;
      logic out_bit;
      logic out_en;
      logic prog_en;
      logic we;
      logic [31:0] timer;
   } state_t;
   state_t s_r, s_nxt;
   logic sk, sel_n, din, rst_pin;
   logic [15:0] rdata;
   logic [AW-1:0] raddr;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   pin_sync #(.INIT(1'b1)) u_sk (.clk(clk), .rst(rst), .pin(shift_clock_n), .level(sk));
   pin_sync #(.INIT(1'b1)) u_cs (.clk(clk), .rst(rst), .pin(select_n), .level(sel_n));
   pin_sync #(.INIT(1'b0)) u_di (.clk(clk), .rst(rst), .pin(serial_in), .level(din));
   pin_sync #(.INIT(1'b0)) u_rs (.clk(clk), .rst(rst), .pin(abort_reset), .level(rst_pin));
   // ----------------------------------------
   // memory
   // ----------------------------------------
   word_mem #(.AW(AW), .DW(WORD_BITS)) u_mem (
      .clk(clk),
      .we(s_r.we),
      .waddr(s_r.addr),
      .wdata(s_r.data),
      .raddr(raddr),
      .rdata(rdata)
   );
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic [AW-1:0] top_addr(input logic [1:0] cap);
      case (cap)
         CAP_SMALL: top_addr = 9'h07F;
         CAP_MIDDLE: top_addr = 9'h0FF;
         default: top_addr = 9'h1FF;
      endcase
   endfunction : top_addr
   function automatic logic [AW-1:0] frame_addr(input logic [7:0] op, input logic [7:0] af);
      case (CAPACITY)
         CAP_SMALL: frame_addr = {2'h0, af[7:1]}; // R5
         CAP_MIDDLE: frame_addr = {1'b0, af};
         default: frame_addr = {op[0], af}; // R7
      endcase
   endfunction : frame_addr
   function automatic logic is_read(input logic [7:0] op);
      if (CAPACITY == CAP_LARGE) begin
         is_read = (op[7:1] == OP_READ_HI); // R7
      end else begin
         is_read = (op == OP_READ); // R4
      end
   endfunction : is_read
   function automatic logic is_write(input logic [7:0] op);
      if (CAPACITY == CAP_LARGE) begin
         is_write = (op[7:1] == OP_WRITE_HI); // R7
      end else begin
         is_write = (op == OP_WRITE); // R4
      end
   endfunction : is_write
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
      if (a == top_addr(CAPACITY)) begin
         next_addr = '0; // R17
      end else begin
         next_addr = a + 9'h001;
      end
   endfunction : next_addr
   logic sk_rise, sk_fall, sel_fall, sel_rise;
   assign sk_rise = sk & ~s_r.sk_d;
   assign sk_fall = ~sk & s_r.sk_d;
   assign sel_fall = ~sel_n & s_r.sel_d;
   assign sel_rise = sel_n & ~s_r.sel_d;
   assign raddr = s_r.addr;
   // ----------------------------------------
   // frame state machine
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sk_d = sk;
      s_nxt.sel_d = sel_n;
      s_nxt.we = 1'b0;
      case (s_r.phase)
         ST_IDLE: begin
            s_nxt.out_en = 1'b0;
            if (sel_fall && sk) begin // R2
               s_nxt.phase = ST_HEADER;
               s_nxt.bitcnt = '0;
            end else if (sel_fall) begin // R24
               s_nxt.phase = ST_STATUS;
            end
         end
         ST_STATUS: begin
            s_nxt.out_en = 1'b1;
            s_nxt.out_bit = 1'b1; // R24
            if (sel_rise) begin
               s_nxt.phase = ST_IDLE;
               s_nxt.out_en = 1'b0;
            end else if (sk_rise && din) begin // R24
               s_nxt.out_en = 1'b0;
               s_nxt.phase = ST_HEADER;
               s_nxt.bitcnt = 6'h01;
               s_nxt.opcode = 8'h01;
            end
         end
         ST_HEADER: begin
            if (sel_rise) begin
               s_nxt.phase = ST_IDLE;
            end else if (sk_rise) begin // R22
               s_nxt.bitcnt = s_r.bitcnt + 6'h01;
               if (s_r.bitcnt < 6'(OPCODE_BITS)) begin // R1
                  s_nxt.opcode = {s_r.opcode[6:0], din};
               end else begin
                  s_nxt.addr_field = {s_r.addr_field[6:0], din};
               end
               if (s_r.bitcnt + 6'h01 == LAST_HEADER_BIT) begin
                  s_nxt.addr = frame_addr(s_r.opcode, {s_r.addr_field[6:0], din});
                  if (is_read(s_r.opcode)) begin // R20
                     s_nxt.phase = ST_READ;
                     s_nxt.rdbit = WORD_LAST_BIT;
                  end else if (is_write(s_r.opcode)) begin
                     s_nxt.phase = ST_WRITE_DATA;
                  end else begin
                     if (s_r.opcode == OP_PROGRAM_ENABLE) begin
                        s_nxt.prog_en = 1'b1; // R6 R19
                     end else if (s_r.opcode == OP_PROGRAM_DISABLE) begin
                        s_nxt.prog_en = 1'b0; // R6 R19
                     end
                     s_nxt.phase = ST_SKIP; // R21 R26 R27
                  end
               end
            end
         end
         ST_WRITE_DATA: begin
            if (sel_rise) begin
               s_nxt.phase = ST_IDLE;
            end else if (sk_rise) begin
               s_nxt.bitcnt = s_r.bitcnt + 6'h01;
               s_nxt.data = {s_r.data[14:0], din}; // R9
               if (s_r.bitcnt + 6'h01 == LAST_WRITE_BIT) begin // R9
                  if (s_r.prog_en && !rst_pin) begin // R13 R18
                     s_nxt.phase = ST_PROGRAM;
                     s_nxt.timer = '0;
                  end else begin
                     s_nxt.phase = ST_SKIP;
                  end
               end
            end
         end
         ST_READ: begin
            if (sel_rise) begin
               s_nxt.phase = ST_IDLE;
               s_nxt.out_en = 1'b0;
            end else if (sk_fall) begin // R15 R22
               s_nxt.out_en = 1'b1;
               s_nxt.out_bit = (s_r.rdbit == WORD_LAST_BIT) ? rdata[15] : s_r.shreg[15];
               s_nxt.shreg = (s_r.rdbit == WORD_LAST_BIT) ? {rdata[14:0], 1'b0}
                                                           : {s_r.shreg[14:0], 1'b0};
               s_nxt.rdbit = s_r.rdbit - 4'h1;
               if (s_r.rdbit == 4'h0) begin
                  s_nxt.addr = next_addr(s_r.addr); // R16 R17
               end
            end
         end
         ST_SKIP: begin
            s_nxt.out_en = 1'b0; // R27
            if (sel_rise) begin
               s_nxt.phase = ST_IDLE;
            end
         end
         ST_PROGRAM: begin
            s_nxt.out_en = 1'b0;
            s_nxt.timer = s_r.timer + 32'h1; // R14 R25
            if (rst_pin) begin
               s_nxt.phase = sel_n ? ST_IDLE : ST_SKIP; // R11 R12
            end else if (s_r.timer + 32'h1 >= 32'(PROG_CYCLES_P)) begin
               s_nxt.we = 1'b1;
               s_nxt.phase = sel_n ? ST_IDLE : ST_SKIP;
            end
         end
         default: begin
            s_nxt.phase = ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '{phase: ST_IDLE, sk_d: 1'b1, sel_d: 1'b1, default: '0}; // R18
      end else begin
         s_r <= s_nxt;
      end
   end
   // ----------------------------------------
   // pins
   // ----------------------------------------
   assign serial_out_o = s_r.out_bit; // R24
   assign serial_out_oe_n = ~s_r.out_en; // R27
   assign ready = (s_r.phase != ST_PROGRAM); // R23
endmodule : eeprom_cmd_port
`default_nettype wire

// >>> tb/eeprom_cmd_port_sva.sv
// concurrent checks on the command port pins
// assumes bind from the testbench top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module eeprom_cmd_port_sva
   import eeprom_pkg::*;
#(
   parameter int PROG_CYCLES_P = 50
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic shift_clock_n,
   input wire logic select_n,
   input wire logic abort_reset,
   // outputs
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n,
   input wire logic ready
);
   int busy_cnt_r;
   logic abort_seen_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_cnt_r <= 0;
         abort_seen_r <= 1'b0;
      end else begin
         busy_cnt_r <= ready ? 0 : busy_cnt_r + 1;
         abort_seen_r <= !ready && (abort_seen_r || abort_reset);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_status_req;
      $fell(select_n) && !shift_clock_n ##1 (!select_n && !shift_clock_n)[*7];
   endsequence
   property p_status;
      s_status_req |=> !serial_out_oe_n && serial_out_o;
   endproperty
   a_status: assert property (p_status) else $error("no ready status");
   property p_sel_hiz;
      select_n[*8] |-> serial_out_oe_n;
   endproperty
   a_sel_hiz: assert property (p_sel_hiz) else $error("driven while deselected");
   property p_busy_hiz;
      !ready |-> serial_out_oe_n;
   endproperty
   a_busy_hiz: assert property (p_busy_hiz) else $error("driven while busy");
   property p_oe_fall;
      $fell(serial_out_oe_n) |-> !shift_clock_n;
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("output on not after fall");
   property p_out_fall;
      !serial_out_oe_n && $past(!serial_out_oe_n) && $changed(serial_out_o) |-> !shift_clock_n;
   endproperty
   a_out_fall: assert property (p_out_fall) else $error("data not after fall");
   property p_protect;
      abort_reset[*8] |-> ready;
   endproperty
   a_protect: assert property (p_protect) else $error("busy under reset pin");
   property p_abort;
      $rose(abort_reset) && !ready |-> ##[1:8] ready;
   endproperty
   a_abort: assert property (p_abort) else $error("abort ignored");
   property p_bound;
      busy_cnt_r <= PROG_CYCLES_P + 1;
   endproperty
   a_bound: assert property (p_bound) else $error("busy too long");
   property p_period;
      $rose(ready) && !abort_seen_r |->
         busy_cnt_r >= PROG_CYCLES_P - 1 && busy_cnt_r <= PROG_CYCLES_P + 1;
   endproperty
   a_period: assert property (p_period) else $error("busy length wrong");
endmodule : eeprom_cmd_port_sva
`default_nettype wire

// >>> tb/host_model.sv
// controller side of the serial port: frames, status probe, reset pin
// assumes inputs change at falling clk edges, pin held 8 clk per level
`timescale 1ns/10ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // pins toward device
   output logic shift_clock_n,
   output logic select_n,
   output logic serial_in,
   output logic abort_reset,
   // resolved device output
   input wire logic serial_out
);
   initial begin
      shift_clock_n = 1'b1;
      select_n = 1'b1;
      serial_in = 1'b0;
      abort_reset = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_clk
   task automatic set_abort(input logic v);
      @(negedge clk);
      abort_reset = v;
   endtask : set_abort
   task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = 64'h0;
      select_n = 1'b0;
      wait_clk(8);
      for (int i = n - 1; i >= 0; i--) begin
         shift_clock_n = 1'b0;
         serial_in = tx[i];
         wait_clk(8);
         rx[i] = serial_out;
         shift_clock_n = 1'b1;
         wait_clk(8);
      end
      select_n = 1'b1;
      serial_in = ~serial_in;
      wait_clk(60);
   endtask : frame
   task automatic probe_frame(input logic [63:0] tx, input int n, output logic st,
      output logic [63:0] rx);
      rx = 64'h0;
      shift_clock_n = 1'b0;
      wait_clk(8);
      select_n = 1'b0;
      wait_clk(12);
      st = serial_out;
      for (int i = n - 1; i >= 0; i--) begin
         shift_clock_n = 1'b0;
         serial_in = tx[i];
         wait_clk(8);
         rx[i] = serial_out;
         shift_clock_n = 1'b1;
         wait_clk(8);
      end
      select_n = 1'b1;
      wait_clk(60);
   endtask : probe_frame
   task automatic status(output logic st);
      shift_clock_n = 1'b0;
      wait_clk(8);
      select_n = 1'b0;
      wait_clk(12);
      st = serial_out;
      select_n = 1'b1;
      wait_clk(8);
      shift_clock_n = 1'b1;
      wait_clk(60);
   endtask : status
endmodule : host_model
`default_nettype wire

// >>> tb/test_eeprom_cmd_port.sv
// testbench top for the command port, large capacity, short write timer
// assumes host_model drives all pins at falling clk edges
`timescale 1ns/10ps
`default_nettype none
module test_eeprom_cmd_port;
   import eeprom_pkg::*;
   localparam int PROG = 50;
   logic clk;
   logic rst;
   wire logic shift_clock_n, select_n, serial_in, abort_reset;
   wire logic serial_out_o, serial_out_oe_n, ready, sdo_pin;
   int num_errors = 0;
   int compares = 0;
   int busy_cycles = 0;
   logic [63:0] rx;
   logic st;
   assign sdo_pin = serial_out_oe_n ? 1'bz : serial_out_o;
   eeprom_cmd_port #(.PROG_CYCLES_P(PROG)) u_dut (.clk(clk), .rst(rst),
      .shift_clock_n(shift_clock_n), .select_n(select_n), .serial_in(serial_in),
      .abort_reset(abort_reset), .serial_out_o(serial_out_o),
      .serial_out_oe_n(serial_out_oe_n), .ready(ready));
   host_model u_host (.clk(clk), .shift_clock_n(shift_clock_n), .select_n(select_n),
      .serial_in(serial_in), .abort_reset(abort_reset), .serial_out(sdo_pin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) if (ready === 1'b0) busy_cycles <= busy_cycles + 1;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cmd(input logic [7:0] op, input int n);
      u_host.frame({op, 56'h0} >> (64 - n), n, rx);
   endtask : cmd
   task automatic wr(input logic [8:0] a, input logic [15:0] d, input logic ok);
      int b;
      b = busy_cycles;
      u_host.frame({32'h0, OP_WRITE_HI, a, d}, 32, rx);
      check({15'h0, busy_cycles != b}, {15'h0, ok});
   endtask : wr
   task automatic rd(input logic [8:0] a, input int n, input logic [31:0] exp);
      u_host.frame({OP_READ_HI, a, 48'h0} >> (48 - 16 * n), 16 + 16 * n, rx);
      check(rx[15:0], exp[15:0]);
      if (n == 2) check(rx[31:16], exp[31:16]);
   endtask : rd
   task automatic t_protect();
      int b;
      wr(9'h105, 16'h1234, 1'b0);
      cmd(OP_PROGRAM_ENABLE, 24);
      b = busy_cycles;
      cmd(8'hB4, 32);
      check({15'h0, busy_cycles != b}, 16'h0);
      wr(9'h105, 16'h1234, 1'b1);
      rd(9'h105, 1, 32'h1234);
      u_host.set_abort(1'b1);
      wr(9'h105, 16'h9999, 1'b0);
      u_host.set_abort(1'b0);
      cmd(OP_PROGRAM_DISABLE, 16);
      wr(9'h105, 16'h5678, 1'b0);
      rd(9'h105, 1, 32'h1234);
      $display("protect test done");
   endtask : t_protect
   task automatic t_abort();
      cmd(OP_PROGRAM_ENABLE, 16);
      wr(9'h007, 16'hAAAA, 1'b1);
      fork
         u_host.frame({32'h0, OP_WRITE_HI, 9'h007, 16'h5555}, 32, rx);
         begin
            wait (ready === 1'b0);
            u_host.set_abort(1'b1);
            u_host.wait_clk(10);
            check({15'h0, ready}, 16'h1);
            u_host.set_abort(1'b0);
         end
      join
      rd(9'h007, 1, 32'hAAAA);
      $display("abort test done");
   endtask : t_abort
   task automatic t_wrap();
      wr(9'h1FF, 16'h0F0F, 1'b1);
      wr(9'h000, 16'hF0F0, 1'b1);
      rd(9'h1FF, 2, 32'h0F0FF0F0);
      u_host.status(st);
      check({15'h0, st}, 16'h1);
      u_host.probe_frame({OP_READ_HI, 9'h000, 48'h0} >> 32, 32, st, rx);
      check({15'h0, st}, 16'h1);
      check(rx[15:0], 16'hF0F0);
      $display("wrap and status test done");
   endtask : t_wrap
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      u_host.wait_clk(10);
      check({14'h0, ready, serial_out_oe_n}, 16'h3);
      t_protect();
      t_abort();
      t_wrap();
      complete_run();
   end
   initial begin
      #400000;
      num_errors++;
      $display("watchdog expired");
      complete_run();
   end
endmodule : test_eeprom_cmd_port
bind eeprom_cmd_port eeprom_cmd_port_sva #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_sva (.clk(clk),
   .rst(rst), .shift_clock_n(shift_clock_n), .select_n(select_n),
   .abort_reset(abort_reset), .serial_out_o(serial_out_o),
   .serial_out_oe_n(serial_out_oe_n), .ready(ready));
`default_nettype wire
